// file: core/lcdscd_pkg.sv
/*
 lcdscd_pkg: register offsets, field positions, reset values, mode codes and
 drive level codes shared by the segment/common LCD driver files.
 Assumes an 8-bit register port and 4-level bias drive codes.
*/
package lcdscd_pkg;
   localparam int ADDR_W    = 8;
   localparam int DATA_W    = 8;
   localparam int NUM_COM   = 4;
   localparam int NUM_SEG   = 16;
   localparam int SEG_REG_N = NUM_SEG / DATA_W;
   localparam int PIX_REG_N = NUM_COM * SEG_REG_N;

   // register byte offsets
   localparam logic [ADDR_W-1:0] OFS_CTRL   = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_PRESC  = 8'h01;
   localparam logic [ADDR_W-1:0] OFS_REG    = 8'h02;
   localparam logic [ADDR_W-1:0] OFS_SEGEN0 = 8'h03;
   localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h05;
   localparam logic [ADDR_W-1:0] OFS_PIX0   = 8'h08;

   // lcd_control_reg fields
   localparam int CTRL_EN_BIT    = 7;
   localparam int CTRL_SLPEN_BIT = 6;
   localparam int CTRL_WAVEB_BIT = 5;
   localparam int CTRL_CS_LO     = 2;
   localparam int CTRL_MUX_LO    = 0;

   // regulator register fields
   localparam int REG_PUMP_BIT  = 6;
   localparam int REG_BIAS_LO   = 3;
   localparam int REG_MODE13_BIT = 2;
   localparam int REG_REGULATOR_CLOCK_SELECT_LO  = 0;

   // status register fields
   localparam int STAT_RUN_BIT    = 0;
   localparam int STAT_STOP_BIT   = 1;
   localparam int STAT_SOFT_BIT   = 2;
   localparam int STAT_HARD_BIT   = 3;
   localparam int STAT_PARITY_BIT = 4;
   localparam int STAT_SLOT_LO    = 5;

   // reset values
   localparam logic [7:0] CTRL_RST  = 8'h00;
   localparam logic [3:0] PRESC_RST = 4'h0;
   localparam logic [6:0] REG_RST   = 7'h3C;

   // multiplex select codes
   localparam logic [1:0] MUX_STATIC  = 2'h0;
   localparam logic [1:0] MUX_HALF    = 2'h1;
   localparam logic [1:0] MUX_THIRD   = 2'h2;
   localparam logic [1:0] MUX_QUARTER = 2'h3;

   // frame clock source: system clock or external source pin
   localparam logic [1:0] CS_SYSCLK = 2'h0;
   localparam logic [1:0] REGULATOR_CLOCK_SELECT_OFF = 2'h0;

   // steps per frame for each multiplex type
   localparam logic [2:0] FACT_STATIC  = 3'h4;
   localparam logic [2:0] FACT_HALF    = 3'h4;
   localparam logic [2:0] FACT_THIRD   = 3'h3;
   localparam logic [2:0] FACT_QUARTER = 3'h4;

   // drive level codes, V0 lowest bias level
   localparam logic [1:0] LVL_V0 = 2'h0;
   localparam logic [1:0] LVL_V1 = 2'h1;
   localparam logic [1:0] LVL_V2 = 2'h2;
   localparam logic [1:0] LVL_V3 = 2'h3;

   typedef enum logic [1:0] {RUN_OFF, RUN_ACTIVE, RUN_STOPPED} lcdscd_run_t;
endpackage

// file: core/lcdscd_sync.sv
/*
 lcdscd_sync: three-flop synchroniser for one asynchronous level.
 Assumes the input may change at any time relative to clk.
*/
`timescale 1ns/1ns
`default_nettype none
module lcdscd_sync (
   input  wire logic clk,
   input  wire logic nrst,
   input  wire logic asyncIn,
   output var  logic syncOut
);
   logic stage1_r;
   logic stage2_r;
   logic stage3_r;

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         stage1_r <= 1'b0;
         stage2_r <= 1'b0;
         stage3_r <= 1'b0;
      end else begin
         stage1_r <= asyncIn;
         stage2_r <= stage1_r;
         stage3_r <= stage2_r;
      end
   end

   // a change is accepted only once the last two stages agree
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         syncOut <= 1'b0;
      end else if (stage2_r == stage3_r) begin
         syncOut <= stage3_r;
      end
   end
endmodule // lcdscd_sync
`default_nettype wire

// file: core/lcdscd_prescaler.sv
/*
 lcdscd_prescaler: 4-bit frame prescaler producing one step pulse per
 (preset+1) source ticks, plus a second-half flag for in-step inversion.
 Assumes srcTick is a one-cycle enable on clk.
*/
`timescale 1ns/1ns
`default_nettype none
module lcdscd_prescaler (
   input  wire logic       clk,
   input  wire logic       nrst,
   input  wire logic       run,
   input  wire logic       srcTick,
   input  wire logic [3:0] presetVal,
   output var  logic       stepTick,
   output var  logic       secondHalf
);
   logic [3:0] cnt_r;
   logic [3:0] lp_r;

   // preset is sampled only at reload or while not running so a mid-step change cannot tear a phase
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         cnt_r <= 4'h0;
         lp_r  <= 4'h0;
      end else if (!run) begin
         cnt_r <= 4'h0;
         lp_r  <= presetVal;
      end else if (srcTick) begin
         if (cnt_r == lp_r) begin
            cnt_r <= 4'h0;
            lp_r  <= presetVal;
         end else begin
            cnt_r <= cnt_r + 4'h1;
         end
      end
   end

   always_comb begin
      stepTick   = run && srcTick && (cnt_r == lp_r);
      secondHalf = cnt_r > (lp_r >> 1);
   end
endmodule // lcdscd_prescaler
`default_nettype wire

// file: core/lcdscd_top.sv
/*
 lcdscd_top: segment LCD driver control: register port, bias ladder mode
 decode, common pin takeover, segment enables, pixel storage, frame timing
 and common/segment drive level generation with sleep handling.
 Assumes a passive multiplexed glass on the level outputs and an analog
 bias block that turns level codes V0..V3 into voltages.
*/
//Functional notes
//- regulator_clock_select zero, pump set: software-contrast ladder
//- regulator_clock_select zero, pump clear: hardware-contrast ladder
//- regulator_clock_select zero disables regulator, nonzero enables
//- software ladder frees flyback pins as I/O
//- bias field sets low level, only soft; the code also applies it while the regulator is on
//- multiplex field selects one to four commons
//- common pins override port function and direction
//- reset clears multiplex field to static
//- set segment enable makes pin segment driver
//- reset clears all segment enable bits
//- one pixel bit per common-segment, all r/w
//- frame equals source/((prescale+1) times factor)
//- commons time-sliced, segments carry pixel data
//- pixel takes only two rms levels
//- type A inverts in slot, B per frame
//- system clock source stops module in sleep
`timescale 1ns/1ns
`default_nettype none
module lcdscd_top
   import lcdscd_pkg::*;
(
   input  wire logic                          clk,
   input  wire logic                          nrst,
   input  wire logic [lcdscd_pkg::ADDR_W-1:0] regAddr,
   input  wire logic [lcdscd_pkg::DATA_W-1:0] regWdata,
   input  wire logic                          regWr,
   input  wire logic                          regRd,
   output var  logic [lcdscd_pkg::DATA_W-1:0] regRdata,
   input  wire logic                          clkSrcPin,
   input  wire logic                          cpuSleep,
   output var  logic [2*lcdscd_pkg::NUM_COM-1:0] comLevel,
   output var  logic [2*lcdscd_pkg::NUM_SEG-1:0] segLevel,
   output var  logic [2:0]                    comPinOverride,
   output var  logic [lcdscd_pkg::NUM_SEG-1:0] segPinEnable,
   output var  logic                          flybackPinsIo,
   output var  logic                          regulatorOn,
   output var  logic                          pumpOn,
   output var  logic                          refOn,
   output var  logic [2:0]                    biasLevelOut,
   output var  logic                          bias13Mode,
   output var  logic                          softLadder,
   output var  logic                          hardLadder,
   output var  logic                          lcdStopped
);
   import lcdscd_pkg::*;

   logic [7:0]        ctrl_r;
   logic [3:0]        presc_r;
   logic [6:0]        regu_r;
   logic [7:0]        segEn_r [SEG_REG_N];
   logic [7:0]        pix_r   [PIX_REG_N];
   logic [7:0]        rdata_nxt;
   logic [1:0]        muxSel;
   logic [1:0]        clkSel;
   logic [1:0]        regulator_clock_select;
   logic              pumpBit;
   logic              srcSync;
   logic              srcSyncD_r;
   logic              sleepSync;
   logic              srcTick;
   logic              stepTick;
   logic              secondHalf;
   logic              stopCond;
   lcdscd_run_t       run_r;
   lcdscd_run_t       run_nxt;
   logic [2:0]        step_r;
   logic              parity_r;
   logic [2:0]        factor;
   logic [1:0]        slot;
   logic              phase;
   logic              active;
   logic [1:0]        comLv_r [NUM_COM];
   logic [1:0]        segLv_r [NUM_SEG];

   assign muxSel  = ctrl_r[CTRL_MUX_LO +: 2];
   assign clkSel  = ctrl_r[CTRL_CS_LO +: 2];
   assign regulator_clock_select   = regu_r[REG_REGULATOR_CLOCK_SELECT_LO +: 2];
   assign pumpBit = regu_r[REG_PUMP_BIT];

   // register writes; any pixel bit not shown still stores like plain RAM
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         ctrl_r  <= CTRL_RST;
         presc_r <= PRESC_RST;
         regu_r  <= REG_RST;
      end else if (regWr) begin
         if (regAddr == OFS_CTRL) begin
            ctrl_r <= regWdata;
         end
         if (regAddr == OFS_PRESC) begin
            presc_r <= regWdata[3:0];
         end
         if (regAddr == OFS_REG) begin
            regu_r <= regWdata[6:0];
         end
      end
   end

   generate
      for (genvar i = 0; i < SEG_REG_N; i++) begin : gSegEn
         always_ff @(posedge clk or negedge nrst) begin
            if (!nrst) begin
               segEn_r[i] <= 8'h00;
            end else if (regWr && regAddr == OFS_SEGEN0 + 8'(i)) begin
               segEn_r[i] <= regWdata;
            end
         end
         always_ff @(posedge clk or negedge nrst) begin
            if (!nrst) begin
               segPinEnable[8*i +: 8] <= 8'h00;
            end else begin
               segPinEnable[8*i +: 8] <= segEn_r[i];
            end
         end
      end
      for (genvar i = 0; i < PIX_REG_N; i++) begin : gPix
         always_ff @(posedge clk or negedge nrst) begin
            if (!nrst) begin
               pix_r[i] <= 8'h00;
            end else if (regWr && regAddr == OFS_PIX0 + 8'(i)) begin
               pix_r[i] <= regWdata;
            end
         end
      end
   endgenerate

   // read data stands for exactly one cycle after the strobe
   always_comb begin
      rdata_nxt = 8'h00;
      if (regAddr == OFS_CTRL) begin
         rdata_nxt = ctrl_r;
      end else if (regAddr == OFS_PRESC) begin
         rdata_nxt = {4'h0, presc_r};
      end else if (regAddr == OFS_REG) begin
         rdata_nxt = {1'b0, regu_r};
      end else if (regAddr == OFS_STATUS) begin
         rdata_nxt[STAT_RUN_BIT]    = (run_r == RUN_ACTIVE);
         rdata_nxt[STAT_STOP_BIT]   = (run_r == RUN_STOPPED);
         rdata_nxt[STAT_SOFT_BIT]   = softLadder;
         rdata_nxt[STAT_HARD_BIT]   = hardLadder;
         rdata_nxt[STAT_PARITY_BIT] = parity_r;
         rdata_nxt[STAT_SLOT_LO +: 2] = slot;
      end else if (regAddr >= OFS_SEGEN0 && regAddr < OFS_SEGEN0 + 8'(SEG_REG_N)) begin
         rdata_nxt = segEn_r[1'(regAddr - OFS_SEGEN0)];
      end else if (regAddr >= OFS_PIX0 && regAddr < OFS_PIX0 + 8'(PIX_REG_N)) begin
         rdata_nxt = pix_r[3'(regAddr - OFS_PIX0)];
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         regRdata <= 8'h00;
      end else begin
         regRdata <= regRd ? rdata_nxt : 8'h00;
      end
   end

   // bias configuration decode
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         softLadder    <= 1'b0;
         hardLadder    <= 1'b0;
         regulatorOn   <= 1'b0;
         pumpOn        <= 1'b0;
         refOn         <= 1'b0;
         flybackPinsIo <= 1'b0;
         biasLevelOut  <= 3'h0;
         bias13Mode    <= 1'b0;
      end else begin
         softLadder    <= (regulator_clock_select == REGULATOR_CLOCK_SELECT_OFF) && pumpBit;
         hardLadder    <= (regulator_clock_select == REGULATOR_CLOCK_SELECT_OFF) && !pumpBit;
         regulatorOn   <= (regulator_clock_select != REGULATOR_CLOCK_SELECT_OFF);
         pumpOn        <= (regulator_clock_select != REGULATOR_CLOCK_SELECT_OFF) && pumpBit;
         refOn         <= (regulator_clock_select != REGULATOR_CLOCK_SELECT_OFF) || pumpBit;
         flybackPinsIo <= (regulator_clock_select == REGULATOR_CLOCK_SELECT_OFF) && pumpBit;
         // in the hardware ladder the reference is off, so the field is ignored
         biasLevelOut  <= (regulator_clock_select == REGULATOR_CLOCK_SELECT_OFF && !pumpBit) ? 3'h0 :
                          regu_r[REG_BIAS_LO +: 3];
         bias13Mode    <= regu_r[REG_MODE13_BIT];
      end
   end

   // common pin takeover follows the field even while the module is off
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         comPinOverride <= 3'h0;
      end else begin
         comPinOverride[0] <= (muxSel != MUX_STATIC);
         comPinOverride[1] <= (muxSel == MUX_THIRD) || (muxSel == MUX_QUARTER);
         comPinOverride[2] <= (muxSel == MUX_QUARTER);
      end
   end

   lcdscd_sync uSrcSync (
      .clk     (clk),
      .nrst    (nrst),
      .asyncIn (clkSrcPin),
      .syncOut (srcSync)
   );

   lcdscd_sync uSleepSync (
      .clk     (clk),
      .nrst    (nrst),
      .asyncIn (cpuSleep),
      .syncOut (sleepSync)
   );

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         srcSyncD_r <= 1'b0;
      end else begin
         srcSyncD_r <= srcSync;
      end
   end

   assign srcTick  = (clkSel == CS_SYSCLK) ? 1'b1 : (srcSync && !srcSyncD_r);
   // the system clock dies with the core, so sleep enable cannot keep it alive
   assign stopCond = sleepSync && (ctrl_r[CTRL_SLPEN_BIT] || clkSel == CS_SYSCLK);

   always_comb begin
      run_nxt = run_r;
      case (run_r)
         RUN_OFF:     run_nxt = ctrl_r[CTRL_EN_BIT] ? RUN_ACTIVE : RUN_OFF;
         RUN_ACTIVE:  run_nxt = !ctrl_r[CTRL_EN_BIT] ? RUN_OFF :
                                (stopCond ? RUN_STOPPED : RUN_ACTIVE);
         RUN_STOPPED: run_nxt = !ctrl_r[CTRL_EN_BIT] ? RUN_OFF :
                                (stopCond ? RUN_STOPPED : RUN_ACTIVE);
         default:     run_nxt = RUN_OFF;
      endcase
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         run_r <= RUN_OFF;
      end else begin
         run_r <= run_nxt;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         lcdStopped <= 1'b0;
      end else begin
         lcdStopped <= (run_nxt == RUN_STOPPED);
      end
   end

   lcdscd_prescaler uPresc (
      .clk        (clk),
      .nrst       (nrst),
      .run        (run_r == RUN_ACTIVE),
      .srcTick    (srcTick),
      .presetVal  (presc_r),
      .stepTick   (stepTick),
      .secondHalf (secondHalf)
   );

   always_comb begin
      case (muxSel)
         MUX_STATIC: begin
            factor = FACT_STATIC;
            slot   = 2'h0;
         end
         MUX_HALF: begin
            factor = FACT_HALF;
            slot   = {1'b0, step_r[0]};
         end
         MUX_THIRD: begin
            factor = FACT_THIRD;
            slot   = step_r[1:0];
         end
         default: begin
            factor = FACT_QUARTER;
            slot   = step_r[1:0];
         end
      endcase
   end

   // frame step counter; a stop holds the position so display resumes in step
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         step_r   <= 3'h0;
         parity_r <= 1'b0;
      end else if (run_r == RUN_OFF) begin
         step_r   <= 3'h0;
         parity_r <= 1'b0;
      end else if (stepTick) begin
         if (step_r >= factor - 3'h1) begin
            step_r   <= 3'h0;
            parity_r <= !parity_r;
         end else begin
            step_r <= step_r + 3'h1;
         end
      end
   end

   // type A: exact zero DC within a slot needs an even (prescale+1)
   assign phase  = ctrl_r[CTRL_WAVEB_BIT] ? parity_r : secondHalf;
   assign active = (run_r == RUN_ACTIVE);

   // symmetric levels about mid-bias keep every pixel DC free, save type A with an odd (prescale+1)
   generate
      for (genvar c = 0; c < NUM_COM; c++) begin : gCom
         always_ff @(posedge clk or negedge nrst) begin
            if (!nrst) begin
               comLv_r[c] <= LVL_V0;
            end else if (!active || 2'(c) > muxSel) begin
               comLv_r[c] <= LVL_V0;
            end else if (2'(c) == slot) begin
               comLv_r[c] <= phase ? LVL_V3 : LVL_V0;
            end else begin
               comLv_r[c] <= phase ? LVL_V1 : LVL_V2;
            end
         end
         assign comLevel[2*c +: 2] = comLv_r[c];
      end
      for (genvar s = 0; s < NUM_SEG; s++) begin : gSeg
         always_ff @(posedge clk or negedge nrst) begin
            if (!nrst) begin
               segLv_r[s] <= LVL_V0;
            end else if (!active || !segEn_r[s/8][s%8]) begin
               segLv_r[s] <= LVL_V0;
            end else if (pix_r[{slot, 1'(s/8)}][s%8]) begin
               segLv_r[s] <= phase ? LVL_V0 : LVL_V3;
            end else if (muxSel == MUX_STATIC) begin
               segLv_r[s] <= phase ? LVL_V3 : LVL_V0;
            end else begin
               segLv_r[s] <= phase ? LVL_V2 : LVL_V1;
            end
         end
         assign segLevel[2*s +: 2] = segLv_r[s];
      end
   endgenerate

   sequence pixWrite_s;
      regWr && regAddr == OFS_PIX0;
   endsequence

   sequence pixReadBack_s;
      regRd && regAddr == OFS_PIX0;
   endsequence

   softLadder_a: assert property (@(posedge clk) disable iff (!nrst)
      (regulator_clock_select == REGULATOR_CLOCK_SELECT_OFF && pumpBit) |=> (softLadder && !pumpOn && refOn))
      else $error("software ladder not entered");

   hardLadder_a: assert property (@(posedge clk) disable iff (!nrst)
      hardLadder |-> (!refOn && !regulatorOn && !softLadder))
      else $error("hardware ladder left reference on");

   regEnable_a: assert property (@(posedge clk) disable iff (!nrst)
      ##1 (regulatorOn == ($past(regulator_clock_select) != REGULATOR_CLOCK_SELECT_OFF)))
      else $error("regulator enable does not follow clock select");

   flybackIo_a: assert property (@(posedge clk) disable iff (!nrst)
      flybackPinsIo == softLadder)
      else $error("flyback pins not freed in software ladder");

   biasHard_a: assert property (@(posedge clk) disable iff (!nrst)
      (hardLadder |-> biasLevelOut == 3'h0) and
      (softLadder |-> biasLevelOut == $past(regu_r[REG_BIAS_LO +: 3])))
      else $error("bias level field handled wrongly");

   comOverride_a: assert property (@(posedge clk) disable iff (!nrst)
      (muxSel == MUX_THIRD) [*2] |-> comPinOverride == 3'h3)
      else $error("third multiplex common pins not taken over");

   resetMux_a: assert property (@(posedge clk)
      $rose(nrst) |-> (muxSel == MUX_STATIC && comPinOverride == 3'h0))
      else $error("multiplex field not static after reset");

   segDisabled_a: assert property (@(posedge clk) disable iff (!nrst)
      !segEn_r[0][0] |=> segLv_r[0] == LVL_V0)
      else $error("disabled segment pin driven");

   pixelRw_a: assert property (@(posedge clk) disable iff (!nrst)
      pixWrite_s ##1 pixReadBack_s |=> regRdata == $past(regWdata, 2))
      else $error("pixel storage readback mismatch");

   frameWrap_a: assert property (@(posedge clk) disable iff (!nrst)
      (stepTick && step_r == factor - 3'h1 && active) |=>
      (step_r == 3'h0 && parity_r != $past(parity_r)))
      else $error("frame did not wrap after factor steps");

   sleepStop_a: assert property (@(posedge clk) disable iff (!nrst)
      (active && stopCond && ctrl_r[CTRL_EN_BIT]) |=> (run_r == RUN_STOPPED)
      ##1 (comLv_r[0] == LVL_V0 && segLv_r[0] == LVL_V0))
      else $error("module did not stop at minimum level in sleep");
endmodule // lcdscd_top
`default_nettype wire

// file: tb/lcdscd_glass.sv
/*
 lcdscd_glass: passive glass model; integrates two pixels on common 0.
 Assumes level codes 0..3 stand for evenly spaced bias voltages.
*/
`timescale 1ns/1ns
`default_nettype none
module lcdscd_glass (
   input  wire logic        clk,
   input  wire logic        clr,
   input  wire logic [7:0]  comLevel,
   input  wire logic [31:0] segLevel,
   output var  int          dcA,
   output var  int          dcB,
   output var  int          rmsA,
   output var  int          rmsB
);
   int dA;
   int dB;
   // the glass sees only common minus segment
   assign dA = int'(comLevel[1:0]) - int'(segLevel[1:0]);
   assign dB = int'(comLevel[1:0]) - int'(segLevel[3:2]);
   always @(posedge clk) begin
      dcA  <= clr ? 0 : dcA + dA;
      dcB  <= clr ? 0 : dcB + dB;
      rmsA <= clr ? 0 : rmsA + dA * dA;
      rmsB <= clr ? 0 : rmsB + dB * dB;
   end
endmodule // lcdscd_glass
`default_nettype wire

// file: tb/tb.sv
/*
 tb: self-checking bench for lcdscd_top with a glass model on the levels.
 Assumes the one-cycle read port of the top module and a 4 ns clock.
*/
`timescale 1ns/1ns
`default_nettype none
module tb;
   import lcdscd_pkg::*;
   logic        clk = 1'b0, nrst = 1'b0, regWr = 1'b0, regRd = 1'b0, rdLast = 1'b0;
   logic        clkSrcPin = 1'b0, cpuSleep = 1'b0, clr = 1'b0, cs0, pmp;
   logic [7:0]  regAddr = 8'h00, regWdata = 8'h00, regRdata, comLevel, pixv[8];
   logic [31:0] segLevel, r;
   logic [15:0] segPinEnable, segDirIn = 16'h0000;
   logic [2:0]  comPinOverride, biasLevelOut;
   logic        flybackPinsIo, regulatorOn, pumpOn, refOn, bias13Mode;
   logic        softLadder, hardLadder, lcdStopped;
   logic [7:0]  expQ[$];
   int          errorCnt = 0, testsRun = 0, cyc = 0, dcA, dcB, rmsA, rmsB;
   int          tMux[4] = '{1, 2, 3, 0}, tP[4] = '{1, 2, 1, 3};
   int          tWb[4] = '{1, 1, 0, 0}, tCs[4] = '{0, 0, 0, 1};
   wire [9:0]   ladSeen = {softLadder, hardLadder, regulatorOn, flybackPinsIo,
                           pumpOn, refOn, bias13Mode, biasLevelOut};
   lcdscd_top dut (.clk, .nrst, .regAddr, .regWdata, .regWr, .regRd, .regRdata,
      .clkSrcPin, .cpuSleep, .comLevel, .segLevel, .comPinOverride, .segPinEnable,
      .flybackPinsIo, .regulatorOn, .pumpOn, .refOn, .biasLevelOut, .bias13Mode,
      .softLadder, .hardLadder, .lcdStopped);
   lcdscd_glass glass (.clk, .clr, .comLevel, .segLevel, .dcA, .dcB, .rmsA, .rmsB);
   always #2 clk = ~clk;
   // external frame source, 6 clk per period, toggling on clk falling edges
   always #12 clkSrcPin = ~clkSrcPin;
   task automatic chk(input string n, input logic [63:0] s, input logic [63:0] e);
      testsRun++;
      if (s !== e) begin
         errorCnt++;
         $display("MISMATCH %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic report_and_stop();
      if (errorCnt == 0 && testsRun > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   // one idle edge after each strobe so no signal is assigned twice per step
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      regAddr <= a;
      regWdata <= d;
      regWr <= 1'b1;
      @(posedge clk);
      regWr <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      regAddr <= a;
      regRd <= 1'b1;
      expQ.push_back(e);
      @(posedge clk);
      regRd <= 1'b0;
      @(posedge clk);
   endtask
   // write then read back with no gap, the tightest legal pairing
   task automatic wrrd(input logic [7:0] a, input logic [7:0] d);
      regAddr <= a;
      regWdata <= d;
      regWr <= 1'b1;
      @(posedge clk);
      regWr <= 1'b0;
      regRd <= 1'b1;
      expQ.push_back(d);
      @(posedge clk);
      regRd <= 1'b0;
      @(posedge clk);
   endtask
   function automatic int fact(input int m);
      case (m)
         0: return int'(FACT_STATIC);
         1: return int'(FACT_HALF);
         2: return int'(FACT_THIRD);
         default: return int'(FACT_QUARTER);
      endcase
   endfunction
   always @(posedge clk) begin
      rdLast <= regRd;
      if (rdLast) chk("regRdata", regRdata, expQ.pop_front());
   end
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         errorCnt++;
         report_and_stop();
      end
   end
   initial begin
      void'($urandom(40));
      repeat (5) @(posedge clk);
      nrst <= 1'b1;
      repeat (2) @(posedge clk);
      chk("ladder", {hardLadder, regulatorOn}, 2'b10);
      chk("comPinOverride", comPinOverride, 3'h0);
      chk("segPinEnable", segPinEnable, 16'h0000);
      rd(OFS_CTRL, CTRL_RST);
      rd(OFS_SEGEN0, 8'h00);
      rd(OFS_SEGEN0 + 8'h01, 8'h00);
      for (int i = 0; i < 8; i++) begin
         r = $urandom;
         cs0 = (i[1:0] == 2'h0);
         pmp = i[2];
         wr(OFS_REG, {1'b0, pmp, r[2:0], r[3], i[1:0]});
         @(posedge clk);
         chk("ladder", ladSeen, {cs0 & pmp, cs0 & !pmp, !cs0, cs0 & pmp,
             !cs0 & pmp, !cs0 | pmp, r[3],
             (cs0 & !pmp) ? 3'h0 : r[2:0]});
      end
      for (int m = 0; m < 4; m++) begin
         wr(OFS_CTRL, 8'(m));
         @(posedge clk);
         chk("comPinOverride", comPinOverride, 3'h7 >> (3 - m));
         rd(OFS_CTRL, 8'(m));
      end
      r = $urandom;
      // software makes every pin it turns into a segment an input first
      segDirIn <= r[15:0] | 16'h00FF;
      wr(OFS_SEGEN0, r[7:0]);
      wr(OFS_SEGEN0 + 8'h01, r[15:8]);
      @(posedge clk);
      chk("segPinEnable", segPinEnable, r[15:0]);
      chk("segDirIn", segPinEnable & ~segDirIn, 16'h0000);
      rd(OFS_SEGEN0 + 8'h01, r[15:8]);
      wr(OFS_SEGEN0, 8'hFF);
      for (int p = 0; p < 8; p++) begin
         pixv[p] = 8'($urandom);
         wr(OFS_PIX0 + 8'(p), pixv[p]);
      end
      for (int p = 0; p < 8; p++) rd(OFS_PIX0 + 8'(p), pixv[p]);
      rd(8'h20, 8'h00);
      // segment 0 dark and segment 1 clear on common 0
      wrrd(OFS_PIX0, 8'h01);
      for (int k = 0; k < 4; k++) begin
         wr(OFS_CTRL, 8'h00);
         wr(OFS_PRESC, 8'(tP[k]));
         wr(OFS_CTRL, {2'b10, tWb[k][0], 1'b0, tCs[k][1:0], tMux[k][1:0]});
         repeat (80) @(posedge clk);
         clr <= 1'b1;
         @(posedge clk);
         clr <= 1'b0;
         // two frames of samples; one edge more since the glass sums by nba
         repeat (2 * fact(tMux[k]) * (tP[k] + 1) * (tCs[k] != 0 ? 6 : 1) + 1) @(posedge clk);
         chk("dcA", 32'(dcA), 32'h0);
         chk("dcB", 32'(dcB), 32'h0);
         chk("rms", rmsA > rmsB, 1'b1);
      end
      wr(OFS_CTRL, 8'h81);
      clr <= 1'b1;
      @(posedge clk);
      clr <= 1'b0;
      repeat (8) @(posedge clk);
      // sleep only where both watched pixels carry no net dc
      while (dcA != 0 || dcB != 0) @(posedge clk);
      cpuSleep <= 1'b1;
      repeat (10) @(posedge clk);
      chk("stopped", {lcdStopped, comLevel, segLevel}, {1'b1, 40'h0});
      cpuSleep <= 1'b0;
      wr(OFS_CTRL, 8'h85);
      cpuSleep <= 1'b1;
      repeat (10) @(posedge clk);
      chk("stopped", lcdStopped, 1'b0);
      report_and_stop();
   end
endmodule // tb
`default_nettype wire
